// ==== tmo_pkg.sv ====
// Purpose: shared constants and types for the 16-bit timer/counter
// Assumes: 32-bit classic wishbone register access
// Notes: offsets are byte addresses of aligned words
package tmo_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] TMO_OFF_CONTROL = 8'h10;
  localparam logic [7:0] TMO_OFF_COUNT_LOW = 8'h14;
  localparam logic [7:0] TMO_OFF_COUNT_HIGH = 8'h18;
  localparam logic [7:0] TMO_OFF_IRQ = 8'h1c;
  localparam logic [7:0] TMO_OFF_PORT = 8'h20;
  // ****************************************
  // control fields
  // ****************************************
  localparam int TMO_BIT_ON = 0;
  localparam int TMO_BIT_CS = 1;
  localparam int TMO_BIT_NOSYNC = 2;
  localparam int TMO_BIT_OSCEN = 3;
  localparam int TMO_BIT_PS_LO = 4;
  localparam int TMO_BIT_FLAG = 0;
  localparam int TMO_BIT_IE = 1;
  localparam logic [7:0] TMO_CONTROL_RST = 8'h00;
  localparam logic [15:0] TMO_COUNT_RST = 16'h0000;
  localparam logic [15:0] TMO_COUNT_MAX = 16'hffff;
  localparam logic [1:0] TMO_DIR_RST = 2'h3;

  typedef struct packed {
    logic [1:0] prescale;
    logic osc_en;
    logic sync_off;
    logic ext_sel;
    logic on;
  } tmo_ctrl_s;
endpackage

// ==== tmo_timer.sv ====
// Purpose: 16-bit timer/counter with prescaler and external clock input
// Assumes: pins are asynchronous and pass two flip-flops first
// Notes: prescaler is a synchronous divider, not a ripple chain
//
// Operation
// - the count is two 8-bit halves, both readable and writable.
// - the count steps up from 0000h to FFFFh and wraps to 0000h.
// - overflow latches a flag; irq only when its enable is set.
// - control bit 1 picks instruction clock (0) or external pin (1).
// - control bit 0 runs the counter; clear stops it.
// - bits 5-4 set prescale 1:1, 1:2, 1:4 or 1:8.
// - with oscillator on, both pins are inputs and read as 0.
// - bit 2 set skips input sync in external mode; ignored otherwise.
// - external mode counts rising edges only.
// - after enable in external mode, a falling edge must come first.
// - either capture/compare unit may clear the count.
// - external input is osc pin when oscillator on, else clock pin.
// - sync happens after the prescaler stage.
`timescale 1ns/1ns
module tmo_timer
  import tmo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic clk_pin_i,
  input wire logic osc_pin_i,
  input wire logic [1:0] cc_reset_i,
  output logic irq_o,
  output logic osc_drive_en_o,
  output logic [1:0] pin_dir_o
);
  // every check runs on clk_i and sleeps through reset
  default clocking chk_cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ****************************************
  // register bus
  // ****************************************
  tmo_ctrl_s ctrl;
  logic [15:0] count;
  logic flag;
  logic irq_en;
  logic [1:0] port_dir;
  logic wr;
  logic wr_lo;
  logic wr_hi;
  logic flag_clr;
  logic [31:0] next_dat;
  logic [1:0] pins_m;
  logic [1:0] pins_s;

  assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign wr_lo = wr && adr_i == TMO_OFF_COUNT_LOW;
  assign wr_hi = wr && adr_i == TMO_OFF_COUNT_HIGH;
  assign flag_clr = wr && adr_i == TMO_OFF_IRQ && !dat_i[TMO_BIT_FLAG];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      // one-cycle ack; drops even while the master holds stb
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= tmo_ctrl_s'(TMO_CONTROL_RST[5:0]);
      irq_en <= 1'b0;
      port_dir <= TMO_DIR_RST;
    end else if (wr) begin
      if (adr_i == TMO_OFF_CONTROL) begin
        ctrl <= tmo_ctrl_s'(dat_i[5:0]);
      end
      if (adr_i == TMO_OFF_IRQ) begin
        irq_en <= dat_i[TMO_BIT_IE];
      end
      if (adr_i == TMO_OFF_PORT) begin
        port_dir <= dat_i[1:0];
      end
    end
  end

  always_comb begin
    next_dat = 32'h0000_0000;
    case (adr_i)
      TMO_OFF_CONTROL: next_dat[5:0] = ctrl;
      TMO_OFF_COUNT_LOW: next_dat[7:0] = count[7:0];
      TMO_OFF_COUNT_HIGH: next_dat[7:0] = count[15:8];
      TMO_OFF_IRQ: next_dat[1:0] = {irq_en, flag};
      // port bits read 0 while the oscillator owns the pins
      TMO_OFF_PORT: next_dat[3:0] = {ctrl.osc_en ? 2'h0 : pins_s,
                                     port_dir};
      default: next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else begin
      dat_o <= next_dat;
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  // only the second stage feeds any logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_m <= 2'h0;
      pins_s <= 2'h0;
    end else begin
      pins_m <= {osc_pin_i, clk_pin_i};
      pins_s <= pins_m;
    end
  end

  // ****************************************
  // pin ownership and oscillator
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_dir_o <= TMO_DIR_RST;
      osc_drive_en_o <= 1'b0;
    end else begin
      pin_dir_o <= ctrl.osc_en ? 2'h3 : port_dir;
      osc_drive_en_o <= ctrl.osc_en;
    end
  end

  // ****************************************
  // edge qualification and prescaler
  // ****************************************
  logic ext_in;
  logic ext_prev;
  logic armed;
  logic ext_rise;
  logic [2:0] pre_cnt;
  logic pre_out;
  logic pre_out_d;
  logic tick_in;
  logic tick;
  logic [2:0] pre_mask;

  // both pins already pass two flops, so nosync only saves a pipe stage
  assign ext_in = ctrl.osc_en ? pins_s[1] : pins_s[0];
  assign ext_rise = ext_in && !ext_prev && armed;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_prev <= 1'b0;
      armed <= 1'b0;
    end else begin
      ext_prev <= ext_in;
      if (!ctrl.on || !ctrl.ext_sel) begin
        armed <= 1'b0;
      end else if (!ext_in && ext_prev) begin
        armed <= 1'b1;
      end
    end
  end

  assign tick_in = ctrl.on && (ctrl.ext_sel ? ext_rise : 1'b1);
  assign pre_mask = 3'((4'h1 << ctrl.prescale) - 4'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt <= 3'h0;
    end else if (wr_lo || wr_hi) begin
      // writing either half restarts the prescaler
      pre_cnt <= 3'h0;
    end else if (tick_in) begin
      pre_cnt <= (pre_cnt & pre_mask) == pre_mask ? 3'h0 : pre_cnt + 3'h1;
    end
  end
  assign pre_out = tick_in && (pre_cnt & pre_mask) == pre_mask;

  // sync stage after the prescaler, used only in external mode with nosync clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_out_d <= 1'b0;
    end else begin
      pre_out_d <= pre_out;
    end
  end
  assign tick = (ctrl.ext_sel && !ctrl.sync_off) ? pre_out_d : pre_out;

  // ****************************************
  // count and overflow
  // ****************************************
  logic wrap;
  assign wrap = tick && count == TMO_COUNT_MAX;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= TMO_COUNT_RST;
    end else if (|cc_reset_i) begin
      // a compare clear beats a software write
      count <= TMO_COUNT_RST;
    end else if (wr_lo) begin
      count[7:0] <= dat_i[7:0];
    end else if (wr_hi) begin
      count[15:8] <= dat_i[7:0];
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag <= 1'b0;
    end else if (wrap && !wr_lo && !wr_hi && !(|cc_reset_i)) begin
      // set wins, so an overflow in the clearing cycle is kept
      flag <= 1'b1;
    end else if (flag_clr) begin
      flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= flag && irq_en;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence at_max_tick;
    tick && count == TMO_COUNT_MAX && !wr_lo && !wr_hi && !(|cc_reset_i);
  endsequence
  sequence synced_pulse;
    ctrl.ext_sel && !ctrl.sync_off && pre_out;
  endsequence
  sequence synced_quiet;
    ctrl.ext_sel && !ctrl.sync_off && !wr && !(|cc_reset_i);
  endsequence

  count_wrap_a: assert property (at_max_tick |=>
    count == 16'h0000 && flag)
    else $error("count did not wrap with flag");
  stopped_hold_a: assert property (!ctrl.on && !wr_lo && !wr_hi
    && !(|cc_reset_i) && !tick |=> $stable(count))
    else $error("count moved while stopped");
  irq_gate_a: assert property (irq_o |->
    $past(flag) && $past(irq_en))
    else $error("irq without enabled flag");
  cc_clear_a: assert property (|cc_reset_i |=>
    count == 16'h0000)
    else $error("capture reset missed");
  pin_input_a: assert property ($past(ctrl.osc_en) |->
    pin_dir_o == 2'h3)
    else $error("pins not forced to input");
  no_arm_a: assert property (ctrl.ext_sel && !armed |=>
    !ext_rise || (!$past(ext_in) && $past(ext_prev)))
    else $error("counted before falling edge");
  timer_step_a: assert property (ctrl.on && !ctrl.ext_sel
    && ctrl.prescale == 2'h0 && $stable(ctrl) && !wr && !(|cc_reset_i)
    |=> count == $past(count) + 16'h0001)
    else $error("timer mode did not step");
  ext_sync_a: assert property (synced_pulse ##1 synced_quiet |=>
    count == $past(count) + 16'h0001)
    else $error("sync stage bypassed");
  flag_hold_a: assert property (flag && !flag_clr |=> flag)
    else $error("flag lost");

  // ****************************************
  // bus and register checks
  // ****************************************
  bus_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  write_low_a: assert property (wr_lo && !(|cc_reset_i) |=>
    count[7:0] == 8'($past(dat_i)))
    else $error("low half write lost");
  write_high_a: assert property (wr_hi && !(|cc_reset_i) |=>
    count[15:8] == 8'($past(dat_i)))
    else $error("high half write lost");
  flag_wins_a: assert property (at_max_tick ##0 flag_clr |=> flag)
    else $error("clear beat overflow");
  irq_follow_a: assert property (flag && irq_en |=> irq_o)
    else $error("enabled flag gave no irq");
  osc_follow_a: assert property (
    osc_drive_en_o == $past(ctrl.osc_en))
    else $error("oscillator enable not followed");
  port_read_a: assert property (ctrl.osc_en && adr_i == TMO_OFF_PORT
    |=> dat_o[3:2] == 2'h0)
    else $error("owned pins did not read 0");
  disarm_a: assert property (!ctrl.on || !ctrl.ext_sel |=> !armed)
    else $error("arming kept while off");
endmodule

// ==== tmo_ext_src.sv ====
// Purpose: external clock source for the timer pins
// Assumes: pins change just after a rising edge of clk_i
// Notes: pins stand still between bursts
`timescale 1ns/1ns
module tmo_ext_src (
  input wire logic clk_i,
  output logic clk_pin_o,
  output logic osc_pin_o
);
  initial begin
    clk_pin_o = 1'b0;
    osc_pin_o = 1'b0;
  end
  // seven cycles a level, well past the two-flop sync
  task automatic drive(input bit osc, input logic v);
    @(posedge clk_i);
    if (osc) osc_pin_o <= v;
    else clk_pin_o <= v;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic pulses(input bit osc, input int n);
    repeat (n) begin
      drive(osc, 1'b1);
      drive(osc, 1'b0);
    end
  endtask
endmodule

// ==== tmo_timer_tb.sv ====
// Purpose: self-checking bench for the 16-bit timer/counter
// Assumes: ack comes one cycle after a request is taken
// Notes: counts under a running clock are checked within a window
`timescale 1ns/1ns
module tmo_timer_tb;
  import tmo_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] q;
  logic [3:0] sel = 4'h0;
  logic [1:0] cc = 2'h0;
  logic [1:0] dir;
  logic ack, irq, osc_drv, clk_pin, osc_pin;
  int n_fail = 0;
  int num_checks = 0;
  int ticks = 0;
  tmo_timer tmo_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(wdat), .dat_o(dat_o), .we_i(we), .sel_i(sel), .cyc_i(cyc),
    .stb_i(stb), .ack_o(ack), .clk_pin_i(clk_pin), .osc_pin_i(osc_pin),
    .cc_reset_i(cc), .irq_o(irq), .osc_drive_en_o(osc_drv),
    .pin_dir_o(dir));
  tmo_ext_src tmo_ext_src_inst (.clk_i(clk_i), .clk_pin_o(clk_pin),
    .osc_pin_o(osc_pin));
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: count %h off window", $time, got);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    we <= w;
    wdat <= d;
    sel <= 4'hf;
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(q, e);
  endtask
  task automatic t_reset();
    chk({28'h0, osc_drv, irq, dir}, 32'h3);
    rd(TMO_OFF_CONTROL, 32'h0);
    rd(8'h04, 32'h0);
    wr(TMO_OFF_COUNT_LOW, 32'ha5);
    wr(TMO_OFF_COUNT_HIGH, 32'h5a);
    rd(TMO_OFF_COUNT_LOW, 32'ha5);
    rd(TMO_OFF_COUNT_HIGH, 32'h5a);
  endtask
  task automatic t_wrap();
    wr(TMO_OFF_COUNT_LOW, 32'hff);
    wr(TMO_OFF_COUNT_HIGH, 32'hff);
    wr(TMO_OFF_CONTROL, 32'h1);
    wr(TMO_OFF_CONTROL, 32'h0);
    rd(TMO_OFF_IRQ, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(TMO_OFF_COUNT_HIGH, 32'h0);
    wr(TMO_OFF_IRQ, 32'h3);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    wr(TMO_OFF_IRQ, 32'h2);
    rd(TMO_OFF_IRQ, 32'h2);
    chk({31'h0, irq}, 32'h0);
  endtask
  // sync-off bit set throughout: internal mode must ignore it
  task automatic t_prescale();
    for (int ps = 0; ps < 4; ps++) begin
      wr(TMO_OFF_CONTROL, 32'h0);
      wr(TMO_OFF_COUNT_LOW, 32'h0);
      wr(TMO_OFF_COUNT_HIGH, 32'h0);
      wr(TMO_OFF_CONTROL, 32'(5 + 16 * ps));
      repeat (64) @(posedge clk_i);
      wr(TMO_OFF_CONTROL, 32'h0);
      bus(TMO_OFF_COUNT_LOW, 1'b0, 32'h0);
      chk_rng(q, 64 >> ps, (72 >> ps) + 1);
    end
  endtask
  task automatic t_ext();
    wr(TMO_OFF_COUNT_LOW, 32'h0);
    wr(TMO_OFF_CONTROL, 32'h7);
    tmo_ext_src_inst.pulses(1'b0, 4);
    rd(TMO_OFF_COUNT_LOW, 32'h3);
    wr(TMO_OFF_CONTROL, 32'h0);
    wr(TMO_OFF_COUNT_LOW, 32'h0);
    wr(TMO_OFF_CONTROL, 32'hf);
    tmo_ext_src_inst.pulses(1'b1, 4);
    tmo_ext_src_inst.pulses(1'b0, 3);
    rd(TMO_OFF_COUNT_LOW, 32'h3);
    tmo_ext_src_inst.drive(1'b0, 1'b1);
    tmo_ext_src_inst.drive(1'b1, 1'b1);
    chk({29'h0, osc_drv, dir}, 32'h7);
    rd(TMO_OFF_PORT, 32'h3);
    wr(TMO_OFF_CONTROL, 32'h0);
    rd(TMO_OFF_PORT, 32'hf);
    chk({29'h0, osc_drv, dir}, 32'h3);
    tmo_ext_src_inst.drive(1'b0, 1'b0);
    tmo_ext_src_inst.drive(1'b1, 1'b0);
    wr(TMO_OFF_COUNT_LOW, 32'h0);
    wr(TMO_OFF_CONTROL, 32'h13);
    tmo_ext_src_inst.pulses(1'b0, 9);
    rd(TMO_OFF_COUNT_LOW, 32'h4);
  endtask
  task automatic t_cc();
    wr(TMO_OFF_CONTROL, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(TMO_OFF_COUNT_LOW, 32'h55);
      @(posedge clk_i);
      cc <= 2'(1 << i);
      @(posedge clk_i);
      cc <= 2'h0;
      rd(TMO_OFF_COUNT_LOW, 32'h0);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_wrap();
    t_prescale();
    t_ext();
    t_cc();
    finish_test();
  end
endmodule
